// >>> hdl/irss_arbiter.sv
// Priority selection over the pending request vector.
// Assumes priorities are packed three bits per request bit position.
`timescale 1ns/1ns
`default_nettype none
module irss_arbiter (
  // Requests and priorities
  input  wire logic [10:0] pend_in,
  input  wire logic [32:0] prio_flat_in,
  input  wire logic [2:0]  floor_in,
  // Selection
  output logic             any_out,
  output logic [3:0]       best_out,
  output logic [2:0]       best_prio_out
);

  logic [2:0] p;

  // Lowest value wins; ties go to the lower bit position
  always_comb begin
    p             = 3'h0;
    any_out       = 1'b0;
    best_out      = 4'h0;
    best_prio_out = 3'h7;
    for (int i = irss_pkg::NSRC - 1; i >= 0; i--) begin
      p = prio_flat_in[i*irss_pkg::PRIO_W +: irss_pkg::PRIO_W];
      if (pend_in[i] && (p <= floor_in) &&
          (!any_out || (p <= best_prio_out))) begin
        any_out       = 1'b1;
        best_out      = 4'(i);
        best_prio_out = p;
      end
    end
  end

endmodule : irss_arbiter
`default_nettype wire

// >>> hdl/irss_pkg.sv
// Constants for the interrupt request, in-service and status block.
// Assumes word-indexed Avalon-MM access with 32-bit data.
package irss_pkg;

  localparam int ADDR_W = 7;
  localparam int DATA_W = 32;
  localparam int NSRC   = 11;
  localparam int PRIO_W = 3;
  localparam int NFLD_A = 8;

  // Register indices; byte address is four times the index
  localparam logic [6:0] IDX_FLOOR    = 7'h2A;
  localparam logic [6:0] IDX_IN_SERVICE_FLAGS_MASTER   = 7'h2C;
  localparam logic [6:0] IDX_PEND     = 7'h2E;
  localparam logic [6:0] IDX_TSTAT    = 7'h30;
  localparam logic [6:0] IDX_PRIO_A   = 7'h40;
  localparam logic [6:0] IDX_PRIO_B   = 7'h41;
  localparam logic [6:0] IDX_IRQ_STAT = 7'h42;
  localparam logic [6:0] IDX_IRQ_MASK = 7'h43;

  // Reset values
  localparam logic [2:0]  FLOOR_RST  = 3'h7;
  localparam logic [31:0] PRIO_A_RST = 32'h00FFFFFF;
  localparam logic [31:0] PRIO_B_RST = 32'h000001FF;
  localparam logic [3:0]  IRQ_MASK_RST = 4'h0;

  // Bit positions of the request, in-service and timer status layouts
  localparam int BIT_TMR   = 0;
  localparam int BIT_D0    = 2;
  localparam int BIT_D1    = 3;
  localparam int BIT_EXT0  = 4;
  localparam int BIT_STMR1 = 4;
  localparam int BIT_STMR2 = 5;
  localparam int BIT_SP1   = 9;
  localparam int BIT_SP0   = 10;
  localparam int BIT_HALT  = 15;

  localparam logic [15:0] MASTER_BITS = 16'h07FD;
  localparam logic [15:0] SLAVE_BITS  = 16'h003D;

  // Sticky event bits
  localparam int EV_NMI  = 0;
  localparam int EV_RETURN_FROM_INTERRUPT_INSTR = 1;
  localparam int EV_TAKE = 2;
  localparam int EV_EOI  = 3;
  localparam int NEV     = 4;

endpackage : irss_pkg

// >>> hdl/irss_top.sv
// Request, in-service, timer status and priority floor registers.
// Assumes sources and the core drive one-cycle pulses on this clock.
`timescale 1ns/1ns
`default_nettype none
module irss_top (
  // Clock and reset
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  // Avalon-MM slave
  input  wire logic [6:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Configuration
  input  wire logic        master_mode_in,
  // Interrupt sources
  input  wire logic [2:0]  timer_req_in,
  input  wire logic        dma0_or_line5_req_in,
  input  wire logic        dma1_or_line6_req_in,
  input  wire logic [4:0]  ext_line_req_in,
  input  wire logic        serial0_enable_in,
  input  wire logic [6:0]  serial0_sources_in,
  input  wire logic        serial1_enable_in,
  input  wire logic [6:0]  serial1_sources_in,
  // Core side
  input  wire logic        nmi_in,
  input  wire logic        return_from_interrupt_instr_in,
  input  wire logic        take_in,
  input  wire logic        end_of_interrupt_write_in,
  input  wire logic [3:0]  end_of_interrupt_bit_in,
  output logic             int_req_out,
  output logic [3:0]       int_src_out,
  // DMA gating
  input  wire logic [1:0]  dma_req_in,
  output logic [1:0]       dma_grant_out,
  output logic             dma_halt_flag_out,
  // Interrupt to software
  output logic             irq_out
);

  // Register state
  logic        ack_q;
  logic [31:0] rdata_q;
  logic        dma_halt_flag_q;
  logic [2:0]  per_timer_request_bits_q;
  logic [1:0]  dma_req_q;
  logic [4:0]  ext_req_q;
  logic [10:0] in_service_q;
  logic [2:0]  priority_floor_field_q;
  logic [31:0] prio_a_q;
  logic [31:0] prio_b_q;
  logic [3:0]  irq_stat_q;
  logic [3:0]  irq_mask_q;

  // Combinational
  logic        req;
  logic        wr_en;
  logic [31:0] wr_word;
  logic [31:0] rd_word;
  logic        serial0_request;
  logic        serial1_request;
  logic        timer_unit_request;
  logic [15:0] pend_master;
  logic [15:0] pend_slave;
  logic [15:0] pending_request_view;
  logic [15:0] in_service_view;
  logic [15:0] timer_status_view;
  logic [32:0] prio_flat;
  logic        arb_any;
  logic [3:0]  arb_best;
  logic [2:0]  arb_prio;
  logic        take_ok;
  logic [10:0] take_vec;
  logic [10:0] eoi_vec;
  logic [2:0]  tmr_clr;
  logic [2:0]  tmr_lowest;
  logic [1:0]  dma_clr;
  logic [4:0]  ext_clr;
  logic [3:0]  events;

  // Byte-lane merge for partial writes
  function automatic logic [31:0] irss_be_merge(
    input logic [31:0] old_v,
    input logic [31:0] new_v,
    input logic [3:0]  be
  );
    logic [31:0] res;
    res = old_v;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return res;
  endfunction : irss_be_merge

  // Picks the layout for the selected mode, clearing unused bits
  function automatic logic [15:0] irss_by_mode(
    input logic        master,
    input logic [15:0] m_view,
    input logic [15:0] s_view
  );
    return master ? (m_view & irss_pkg::MASTER_BITS)
                  : (s_view & irss_pkg::SLAVE_BITS);
  endfunction : irss_by_mode

  // Bus handshake: one wait cycle per access
  assign req                 = avs_read_in | avs_write_in;
  assign avs_waitrequest_out = req & ~ack_q;
  assign wr_en               = avs_write_in & ack_q;

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req & ~ack_q;
    end
  end

  // Source views and layouts
  assign serial0_request    = serial0_enable_in & (|serial0_sources_in);
  assign serial1_request    = serial1_enable_in & (|serial1_sources_in);
  assign timer_unit_request = |per_timer_request_bits_q;

  assign pend_master = {5'h00, serial0_request, serial1_request, ext_req_q,
                        dma_req_q[1], dma_req_q[0], 1'b0, timer_unit_request};
  assign pend_slave  = {10'h000, per_timer_request_bits_q[2],
                        per_timer_request_bits_q[1], dma_req_q[1],
                        dma_req_q[0], 1'b0, per_timer_request_bits_q[0]};

  assign pending_request_view = irss_by_mode(master_mode_in, pend_master,
                                             pend_slave);
  assign in_service_view = irss_by_mode(master_mode_in,
                                        {5'h00, in_service_q},
                                        {5'h00, in_service_q});
  assign timer_status_view = {dma_halt_flag_q, 12'h000,
                              per_timer_request_bits_q};

  // Arbitration under the floor
  assign prio_flat = {prio_b_q[8:0], prio_a_q[23:0]};

  irss_arbiter u_arbiter (
    .pend_in       (pending_request_view[10:0]),
    .prio_flat_in  (prio_flat),
    .floor_in      (priority_floor_field_q),
    .any_out       (arb_any),
    .best_out      (arb_best),
    .best_prio_out (arb_prio)
  );

  assign int_req_out = arb_any;
  assign int_src_out = arb_best;
  // A take without a permitted request is ignored
  assign take_ok     = take_in & arb_any;
  assign take_vec    = take_ok ? 11'(11'h001 << arb_best) : 11'h000;
  assign eoi_vec     = end_of_interrupt_write_in ?
                       11'(11'h001 << end_of_interrupt_bit_in) : 11'h000;

  // Acknowledge clears; timer unit take clears lowest pending timer
  assign tmr_lowest = per_timer_request_bits_q &
                      (~per_timer_request_bits_q + 3'h1);
  assign tmr_clr = master_mode_in ?
                   (take_vec[irss_pkg::BIT_TMR] ? tmr_lowest : 3'h0) :
                   {take_vec[irss_pkg::BIT_STMR2],
                    take_vec[irss_pkg::BIT_STMR1],
                    take_vec[irss_pkg::BIT_TMR]};
  assign dma_clr = {take_vec[irss_pkg::BIT_D1], take_vec[irss_pkg::BIT_D0]};
  assign ext_clr = master_mode_in ? take_vec[8:4] : 5'h00;

  // Pending latches; a new request wins over its acknowledge
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      per_timer_request_bits_q <= 3'h0;
    end else begin
      per_timer_request_bits_q <= (per_timer_request_bits_q & ~tmr_clr) |
                                  timer_req_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      dma_req_q <= 2'h0;
    end else begin
      dma_req_q <= (dma_req_q & ~dma_clr) |
                   {dma1_or_line6_req_in, dma0_or_line5_req_in};
    end
  end

  // External lines exist only in the master layout
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      ext_req_q <= 5'h00;
    end else begin
      ext_req_q <= (ext_req_q & ~ext_clr) |
                   (master_mode_in ? ext_line_req_in : 5'h00);
    end
  end

  // In-service: take wins over end-of-interrupt on the same bit
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      in_service_q <= 11'h000;
    end else begin
      in_service_q <= (in_service_q & ~eoi_vec) | take_vec;
    end
  end

  // Halt flag: hardware set beats hardware clear beats software
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      dma_halt_flag_q <= 1'b0;
    end else if (nmi_in) begin
      dma_halt_flag_q <= 1'b1;
    end else if (return_from_interrupt_instr_in) begin
      dma_halt_flag_q <= 1'b0;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_TSTAT &&
                 avs_byteenable_in[1]) begin
      dma_halt_flag_q <= avs_writedata_in[irss_pkg::BIT_HALT];
    end
  end

  assign dma_halt_flag_out = dma_halt_flag_q;
  assign dma_grant_out     = dma_halt_flag_q ? 2'h0 : dma_req_in;

  // Software-written registers
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      priority_floor_field_q <= irss_pkg::FLOOR_RST;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_FLOOR &&
                 avs_byteenable_in[0]) begin
      // Reserved upper bits are dropped on write
      priority_floor_field_q <= avs_writedata_in[2:0];
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      prio_a_q <= irss_pkg::PRIO_A_RST;
      prio_b_q <= irss_pkg::PRIO_B_RST;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_PRIO_A) begin
      prio_a_q <= irss_be_merge(prio_a_q, avs_writedata_in,
                                avs_byteenable_in) & irss_pkg::PRIO_A_RST;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_PRIO_B) begin
      prio_b_q <= irss_be_merge(prio_b_q, avs_writedata_in,
                                avs_byteenable_in) & irss_pkg::PRIO_B_RST;
    end
  end

  // Sticky events, write one to clear; a new event wins
  assign events = {end_of_interrupt_write_in, take_ok,
                   return_from_interrupt_instr_in, nmi_in};
  assign wr_word = irss_be_merge(32'h00000000, avs_writedata_in,
                                 avs_byteenable_in);

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_stat_q <= 4'h0;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_IRQ_STAT) begin
      irq_stat_q <= (irq_stat_q & ~wr_word[3:0]) | events;
    end else begin
      irq_stat_q <= irq_stat_q | events;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      irq_mask_q <= irss_pkg::IRQ_MASK_RST;
    end else if (wr_en && avs_address_in == irss_pkg::IDX_IRQ_MASK &&
                 avs_byteenable_in[0]) begin
      irq_mask_q <= avs_writedata_in[3:0];
    end
  end

  assign irq_out = |(irq_stat_q & irq_mask_q);

  // Read mux; unmapped indices read zero
  always_comb begin
    unique case (avs_address_in)
      irss_pkg::IDX_FLOOR:    rd_word = {29'h00000000, priority_floor_field_q};
      irss_pkg::IDX_IN_SERVICE_FLAGS_MASTER:   rd_word = {16'h0000, in_service_view};
      irss_pkg::IDX_PEND:     rd_word = {16'h0000, pending_request_view};
      irss_pkg::IDX_TSTAT:    rd_word = {16'h0000, timer_status_view};
      irss_pkg::IDX_PRIO_A:   rd_word = prio_a_q;
      irss_pkg::IDX_PRIO_B:   rd_word = prio_b_q;
      irss_pkg::IDX_IRQ_STAT: rd_word = {28'h0000000, irq_stat_q};
      irss_pkg::IDX_IRQ_MASK: rd_word = {28'h0000000, irq_mask_q};
      default:                rd_word = 32'h00000000;
    endcase
  end

  // Captured in the wait cycle, held through the answering cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      rdata_q <= 32'h00000000;
    end else if (avs_read_in && !ack_q) begin
      rdata_q <= rd_word;
    end
  end

  assign avs_readdata_out = rdata_q;

  default clocking irss_cb @(posedge ref_clk_in);
  endclocking
  default disable iff (!rst_n_in);

  a_dma_halt_gate: assert property (
    dma_halt_flag_q |-> (dma_grant_out == 2'h0))
    else $error("DMA granted while halted");

  a_halt_nmi_set: assert property (
    nmi_in |=> dma_halt_flag_out ##0 dma_grant_out == 2'h0)
    else $error("Halt flag not set by NMI");

  a_halt_return_from_interrupt_instr_clear: assert property (
    (return_from_interrupt_instr_in && !nmi_in) |=> !dma_halt_flag_q)
    else $error("Halt flag not cleared on return");

  a_timer_status_bits: assert property (
    (timer_req_in != 3'h0) |=>
    ((timer_status_view[2:0] & $past(timer_req_in)) == $past(timer_req_in)))
    else $error("Timer request not shown in status");

  a_master_timer_or: assert property (
    master_mode_in |->
    (pending_request_view[0] == (timer_status_view[2:0] != 3'h0)))
    else $error("Master timer bit not OR of timers");

  a_serial_or_bits: assert property (
    master_mode_in |-> (pending_request_view[10:9] ==
    {serial0_enable_in && serial0_sources_in != 7'h00,
     serial1_enable_in && serial1_sources_in != 7'h00}))
    else $error("Serial request bits wrong");

  a_slave_layout_bits: assert property (
    !master_mode_in |-> ((pending_request_view & ~16'h003D) == 16'h0000 &&
    pending_request_view[5:4] == per_timer_request_bits_q[2:1]))
    else $error("Slave request layout wrong");

  a_slave_ack_clear: assert property (
    (take_ok && !master_mode_in && arb_best == 4'h2 &&
     !dma0_or_line5_req_in) |=> !pending_request_view[2])
    else $error("Slave acknowledge did not clear request");

  a_inservice_on_take: assert property (
    take_ok |=> in_service_q[$past(arb_best)] ##1 1'b1)
    else $error("In-service bit not set on take");

  a_floor_blocks_req: assert property (
    int_req_out |-> (arb_prio <= priority_floor_field_q))
    else $error("Request above the floor passed");

  a_floor_reset_val: assert property (
    $rose(rst_n_in) |-> (priority_floor_field_q == 3'h7 &&
    prio_a_q == 32'h00FFFFFF))
    else $error("Floor or priorities not at reset value");

  a_read_one_wait: assert property (
    (avs_read_in && !ack_q) |-> avs_waitrequest_out ##1 !avs_waitrequest_out)
    else $error("Read wait cycle wrong");

  c_nmi_halt: cover property (nmi_in ##1 dma_halt_flag_q);
  c_take_then_eoi: cover property (take_ok ##[1:20] end_of_interrupt_write_in);
  c_read_pending: cover property (
    avs_read_in && avs_address_in == irss_pkg::IDX_PEND && ack_q);
  c_irq_raised: cover property (!irq_out ##1 irq_out);

endmodule : irss_top
`default_nettype wire

// >>> tb/irss_core_model.sv
// Core and source model: pulses requests, takes, ends service.
// Assumes the block samples every control on the rising clock edge.
`timescale 1ns/1ns
`default_nettype none
module irss_core_model (
  // Clock and request from the block
  input  wire logic ref_clk_in,
  input  wire logic int_req_in,
  // Source requests
  output logic [2:0] timer_req_out,
  output logic       dma0_req_out,
  output logic       dma1_req_out,
  output logic [4:0] ext_req_out,
  // Core controls
  output logic       nmi_out,
  output logic       return_from_interrupt_instr_out,
  output logic       take_out,
  output logic       eoi_out,
  output logic [3:0] eoi_bit_out
);
  logic [9:0] src_q;
  assign {ext_req_out, dma1_req_out, dma0_req_out, timer_req_out} = src_q;
  initial begin
    src_q = 10'h000;
    {nmi_out, return_from_interrupt_instr_out, take_out, eoi_out} = 4'h0;
    eoi_bit_out = 4'hF;
  end
  // Index: timers 0-2, dma0 3, dma1 4, lines 5-9
  task automatic src_pulse(input int idx);
    @(posedge ref_clk_in);
    src_q <= 10'h001 << idx;
    @(posedge ref_clk_in);
    src_q <= 10'h000;
  endtask : src_pulse
  // Real core is not always prompt; lat adds a slow answer
  task automatic take_req(input int lat);
    int n;
    n = 0;
    repeat (lat) @(posedge ref_clk_in);
    do begin
      @(negedge ref_clk_in);
      n++;
    end while (int_req_in !== 1'b1 && n < 20);
    if (int_req_in === 1'b1) begin
      @(posedge ref_clk_in);
      take_out <= 1'b1;
      @(posedge ref_clk_in);
      take_out <= 1'b0;
    end
  endtask : take_req
  // Handler ends service before it returns
  task automatic end_service(input logic [3:0] b);
    @(posedge ref_clk_in);
    eoi_out     <= 1'b1;
    eoi_bit_out <= b;
    @(posedge ref_clk_in);
    eoi_out     <= 1'b0;
    eoi_bit_out <= ~b; // Stale index is inverted; unused while eoi_out is low
  endtask : end_service
  task automatic ctl_pulse(input logic is_return_from_interrupt_instr);
    @(posedge ref_clk_in);
    nmi_out  <= ~is_return_from_interrupt_instr;
    return_from_interrupt_instr_out <= is_return_from_interrupt_instr;
    @(posedge ref_clk_in);
    nmi_out  <= 1'b0;
    return_from_interrupt_instr_out <= 1'b0;
  endtask : ctl_pulse
endmodule : irss_core_model
`default_nettype wire

// >>> tb/irss_top_tb.sv
// Self-checking bench for the interrupt status block.
// Assumes the core model drives the timer, DMA and line source ports and the core ports; the bench drives the serial ones.
`timescale 1ns/1ns
`default_nettype none
module irss_top_tb;
  logic        clk;
  logic        rst_n;
  logic [6:0]  addr;
  logic        rd_en;
  logic        wr_en;
  logic [31:0] wdata;
  logic [3:0]  be;
  logic [31:0] rdata;
  logic        waitreq;
  logic        master;
  logic [2:0]  tmr;
  logic        d0;
  logic        d1;
  logic [4:0]  ext;
  logic        s0_en;
  logic [6:0]  s0_src;
  logic        s1_en;
  logic [6:0]  s1_src;
  logic        nmi;
  logic        return_from_interrupt_instr;
  logic        take;
  logic        end_of_interrupt_write;
  logic [3:0]  eoi_bit;
  logic        int_req;
  logic [3:0]  int_src;
  logic [1:0]  dma_req;
  logic [1:0]  grant;
  logic        halt;
  logic        irq;
  int          fail_count;
  int          comparisons;
  int          sbit[5] = '{0, 4, 5, 2, 3};

  irss_top DUT (
    .ref_clk_in(clk), .rst_n_in(rst_n), .avs_address_in(addr),
    .avs_read_in(rd_en), .avs_write_in(wr_en), .avs_writedata_in(wdata),
    .avs_byteenable_in(be), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq), .master_mode_in(master),
    .timer_req_in(tmr), .dma0_or_line5_req_in(d0),
    .dma1_or_line6_req_in(d1), .ext_line_req_in(ext),
    .serial0_enable_in(s0_en), .serial0_sources_in(s0_src),
    .serial1_enable_in(s1_en), .serial1_sources_in(s1_src),
    .nmi_in(nmi), .return_from_interrupt_instr_in(return_from_interrupt_instr), .take_in(take),
    .end_of_interrupt_write_in(end_of_interrupt_write), .end_of_interrupt_bit_in(eoi_bit),
    .int_req_out(int_req), .int_src_out(int_src), .dma_req_in(dma_req),
    .dma_grant_out(grant), .dma_halt_flag_out(halt), .irq_out(irq));

  irss_core_model CORE (
    .ref_clk_in(clk), .int_req_in(int_req), .timer_req_out(tmr),
    .dma0_req_out(d0), .dma1_req_out(d1), .ext_req_out(ext),
    .nmi_out(nmi), .return_from_interrupt_instr_out(return_from_interrupt_instr), .take_out(take), .eoi_out(end_of_interrupt_write),
    .eoi_bit_out(eoi_bit));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : stop_test

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // Request held until waitrequest is sampled low at a rising edge
  task automatic bus(input logic w, input logic [6:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk);
    addr  <= a;
    wdata <= wd;
    wr_en <= w;
    rd_en <= ~w;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clk);
    end while (waitreq !== 1'b0);
    rd = rdata;
    wr_en <= 1'b0;
    rd_en <= 1'b0;
  endtask : bus

  task automatic wr(input logic [6:0] a, input logic [31:0] v);
    logic [31:0] x;
    bus(1'b1, a, v, x);
  endtask : wr

  task automatic rchk(input logic [6:0] a, input logic [31:0] exp);
    logic [31:0] x;
    bus(1'b0, a, 32'h00000000, x);
    chk(x, exp);
  endtask : rchk

  task automatic reset_dut(input logic m);
    @(posedge clk);
    rst_n  <= 1'b0;
    master <= m;
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    rchk(irss_pkg::IDX_FLOOR, 32'h00000007);
    rchk(irss_pkg::IDX_IN_SERVICE_FLAGS_MASTER, 32'h00000000);
    rchk(irss_pkg::IDX_TSTAT, 32'h00000000);
    rchk(irss_pkg::IDX_PRIO_A, irss_pkg::PRIO_A_RST);
    rchk(irss_pkg::IDX_PRIO_B, irss_pkg::PRIO_B_RST);
    rchk(irss_pkg::IDX_IRQ_MASK, 32'h00000000);
    rchk(7'h10, 32'h00000000);
  endtask : reset_dut

  // Request, take and end of service for one source
  task automatic walk(input int idx, input int pb, input logic [2:0] tb);
    CORE.src_pulse(idx);
    rchk(irss_pkg::IDX_PEND, 32'h1 << pb);
    rchk(irss_pkg::IDX_TSTAT, {29'h0, tb});
    @(negedge clk);
    chk({27'h0, int_req, int_src}, 32'h10 | pb);
    CORE.take_req(idx % 3);
    rchk(irss_pkg::IDX_IN_SERVICE_FLAGS_MASTER, 32'h1 << pb);
    rchk(irss_pkg::IDX_PEND, 32'h00000000);
    rchk(irss_pkg::IDX_TSTAT, 32'h00000000);
    CORE.end_service(4'(pb));
    rchk(irss_pkg::IDX_IN_SERVICE_FLAGS_MASTER, 32'h00000000);
  endtask : walk

  initial begin
    repeat (20000) @(posedge clk);
    fail_count++;
    $display("[ERR] %0t watchdog expired", $time);
    stop_test();
  end

  initial begin
    fail_count  = 0;
    comparisons = 0;
    rst_n  = 1'b0;
    addr   = 7'h00;
    rd_en  = 1'b0;
    wr_en  = 1'b0;
    wdata  = 32'h00000000;
    be     = 4'hF;
    master = 1'b1;
    s0_en  = 1'b0;
    s1_en  = 1'b0;
    s0_src = 7'h00;
    s1_src = 7'h00;
    dma_req = 2'h3;
    reset_dut(1'b1);
    wr(irss_pkg::IDX_FLOOR, 32'hFFFFFFFF);
    rchk(irss_pkg::IDX_FLOOR, 32'h00000007);
    // Lane 0 off: the floor field must keep its value
    be <= 4'hE;
    wr(irss_pkg::IDX_FLOOR, 32'h00000000);
    be <= 4'hF;
    rchk(irss_pkg::IDX_FLOOR, 32'h00000007);
    wr(irss_pkg::IDX_PEND, 32'h0000FFFF);
    rchk(irss_pkg::IDX_PEND, 32'h00000000);
    $display("test reset done");
    for (int i = 0; i < 10; i++) begin
      walk(i, (i < 3) ? 0 : i - 1, (i < 3) ? 3'h1 << i : 3'h0);
    end
    $display("test master layout done");
    for (int k = 0; k < 7; k++) begin
      @(posedge clk);
      s0_en  <= 1'b1;
      s1_en  <= 1'b1;
      s0_src <= 7'h01 << k;
      s1_src <= 7'h40 >> k;
      rchk(irss_pkg::IDX_PEND, 32'h00000600);
    end
    @(posedge clk);
    s0_en <= 1'b0;
    s1_en <= 1'b0;
    rchk(irss_pkg::IDX_PEND, 32'h00000000);
    @(posedge clk);
    s0_src <= 7'h00;
    s1_src <= 7'h00;
    $display("test serial done");
    CORE.src_pulse(0);
    wr(irss_pkg::IDX_FLOOR, 32'h00000006);
    @(negedge clk);
    chk({31'h0, int_req}, 32'h0);
    wr(irss_pkg::IDX_PRIO_A, 32'h00FFFFFE);
    @(negedge clk);
    chk({31'h0, int_req}, 32'h1);
    CORE.take_req(0);
    CORE.end_service(4'h0);
    wr(irss_pkg::IDX_PRIO_A, irss_pkg::PRIO_A_RST);
    wr(irss_pkg::IDX_FLOOR, 32'h00000007);
    $display("test floor done");
    wr(irss_pkg::IDX_IRQ_STAT, 32'h0000000F);
    CORE.ctl_pulse(1'b0);
    @(negedge clk);
    chk({29'h0, halt, grant}, 32'h4);
    rchk(irss_pkg::IDX_TSTAT, 32'h00008000);
    rchk(irss_pkg::IDX_IRQ_STAT, 32'h00000001);
    // Registers settle after the taken edge; look mid-cycle
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(irss_pkg::IDX_IRQ_MASK, 32'h00000001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    wr(irss_pkg::IDX_IRQ_STAT, 32'h00000001);
    @(negedge clk);
    chk({31'h0, irq}, 32'h0);
    CORE.ctl_pulse(1'b1);
    dma_req <= 2'h2;
    @(negedge clk);
    chk({29'h0, halt, grant}, 32'h2);
    wr(irss_pkg::IDX_TSTAT, 32'h00008000);
    @(negedge clk);
    chk({29'h0, halt, grant}, 32'h4);
    wr(irss_pkg::IDX_TSTAT, 32'h00000000);
    rchk(irss_pkg::IDX_TSTAT, 32'h00000000);
    $display("test halt done");
    reset_dut(1'b0);
    rchk(irss_pkg::IDX_PEND, 32'h00000000);
    for (int i = 0; i < 5; i++) begin
      walk(i, sbit[i], (i < 3) ? 3'h1 << i : 3'h0);
    end
    CORE.src_pulse(7);
    rchk(irss_pkg::IDX_PEND, 32'h00000000);
    $display("test slave layout done");
    stop_test();
  end
endmodule : irss_top_tb
`default_nettype wire
